// ### hdl/pix_gain_offset.sv
`timescale 1ns/10ps
module pix_gain_offset
    import pgo_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [11:0] PIX_DATA,
    input wire logic PIX_VALID,
    output logic PIX_READY,
    output logic [11:0] VID_DATA,
    output logic VID_VALID,
    input wire logic VID_READY,
    input wire logic LINE_TRIG,
    output logic LINE_VALID
);

    // ------------------------------------------------------------------
    // Clamping helpers
    // ------------------------------------------------------------------
    function automatic logic [13:0] gain_max(input logic [1:0] d);
        gain_max = (d == DEPTH_8B) ? GAIN_MAX_8B :
                   (d == DEPTH_10B) ? GAIN_MAX_10B : GAIN_MAX_12B;
    endfunction

    function automatic logic signed [12:0] offs_lim(input logic [1:0] d);
        offs_lim = (d == DEPTH_8B) ? OFFS_LIM_8B :
                   (d == DEPTH_10B) ? OFFS_LIM_10B : OFFS_LIM_12B;
    endfunction

    function automatic logic [13:0] clamp_gain(input logic [15:0] v,
                                               input logic [1:0] d);
        logic [13:0] mx;
        mx = gain_max(d);
        if (v < {2'h0, GAIN_MIN}) clamp_gain = GAIN_MIN;
        else if (v > {2'h0, mx}) clamp_gain = mx;
        else clamp_gain = v[13:0];
    endfunction

    function automatic logic signed [12:0] clamp_offs(
        input logic signed [20:0] v, input logic [1:0] d);
        logic signed [20:0] lim;
        lim = 21'(offs_lim(d));
        if (v > lim) clamp_offs = lim[12:0];
        else if (v < -lim) clamp_offs = 13'(-lim);
        else clamp_offs = v[12:0];
    endfunction

    // Whole-decibel gain table, rounded 4096 * 10^(dB/20) from -3 dB.
    function automatic logic [15:0] db_to_gain(input logic signed [7:0] db);
        logic [3:0] i;
        i = 4'(db - DB_MIN);
        case (i)
            4'h0: db_to_gain = 16'h0b54;
            4'h1: db_to_gain = 16'h0cb6;
            4'h2: db_to_gain = 16'h0e43;
            4'h3: db_to_gain = 16'h1000;
            4'h4: db_to_gain = 16'h11f4;
            4'h5: db_to_gain = 16'h1425;
            4'h6: db_to_gain = 16'h169a;
            4'h7: db_to_gain = 16'h195c;
            4'h8: db_to_gain = 16'h1c74;
            4'h9: db_to_gain = 16'h1fed;
            4'ha: db_to_gain = 16'h23d2;
            4'hb: db_to_gain = 16'h2831;
            4'hc: db_to_gain = 16'h2d18;
            4'hd: db_to_gain = 16'h3299;
            4'he: db_to_gain = 16'h38c5;
            default: db_to_gain = 16'h3fb2;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------------
    logic [1:0] depth, next_depth;
    logic [1:0] prof, next_prof;
    logic [13:0] gain, next_gain;
    logic signed [7:0] gain_db, next_gain_db;
    logic signed [12:0] offs, next_offs;
    logic range_err, next_range_err;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic access, wr, mapped;
    logic signed [7:0] db_in;
    logic signed [20:0] offs_req;
    logic [15:0] gain_req;
    logic lval, busy;

    // One wait state. A write lands on the edge that samples PREADY
    // high, so a master that abandons the access early changes nothing.
    always_comb begin
        access = PSEL && PENABLE && !PREADY;
        wr = PSEL && PENABLE && PREADY && PWRITE;
        mapped = (PADDR <= ADDR_STATUS) && (PADDR[1:0] == 2'h0);
        next_depth = depth;
        next_prof = prof;
        next_gain = gain;
        next_gain_db = gain_db;
        next_offs = offs;
        next_range_err = range_err;
        db_in = $signed(PWDATA[7:0]);
        gain_req = PWDATA[15:0];
        offs_req = 21'($signed(PWDATA[15:0]));
        if (wr) begin
            case (PADDR)
                ADDR_CTRL: begin
                    next_depth = (PWDATA[1:0] > DEPTH_12B) ? DEPTH_12B :
                                 PWDATA[CTRL_DEPTH_LSB +: 2];
                    next_prof = (PWDATA[3:2] > PROF_DUAL_80) ? PROF_DUAL_80 :
                                PWDATA[CTRL_PROF_LSB +: 2];
                    // A narrower depth tightens the offset limit and widens the gain limit on stored values.
                    next_gain = clamp_gain({2'h0, gain}, next_depth);
                    next_offs = clamp_offs(21'(offs), next_depth);
                end
                ADDR_GAIN_RAW: begin
                    next_gain = clamp_gain(gain_req, depth);
                    next_range_err = (16'(next_gain) != gain_req);
                end
                ADDR_GAIN_ABS: begin
                    next_gain_db = (db_in < DB_MIN) ? DB_MIN :
                                   (db_in > DB_MAX) ? DB_MAX : db_in;
                    next_gain = clamp_gain(db_to_gain(next_gain_db),
                                           depth);
                    next_range_err = (next_gain_db != db_in) ||
                        (16'(next_gain) != db_to_gain(next_gain_db));
                end
                ADDR_OFFS_RAW: begin
                    next_offs = clamp_offs(offs_req, depth);
                    next_range_err = (21'(next_offs) != offs_req);
                end
                ADDR_OFFS_ABS: begin
                    // Counts scale to raw units of the active depth.
                    if (depth == DEPTH_8B) begin
                        offs_req = offs_req <<< OFFS_SHIFT_8B;
                    end else if (depth == DEPTH_10B) begin
                        offs_req = offs_req <<< OFFS_SHIFT_10B;
                    end
                    next_offs = clamp_offs(offs_req, depth);
                    next_range_err = (21'(next_offs) != offs_req);
                end
                default: begin
                end
            endcase
            // A status write with the range bit set clears the flag; an error on any other write sets it.
            if (PADDR == ADDR_STATUS && PWDATA[STAT_RANGE_BIT]) begin
                next_range_err = 1'b0;
            end else if (PADDR != ADDR_STATUS && next_range_err) begin
                next_range_err = 1'b1;
            end else begin
                next_range_err = range_err;
            end
        end
        next_pready = access;
        next_pslverr = access && !mapped;
        next_prdata = 32'h0;
        if (access && !PWRITE) begin
            case (PADDR)
                ADDR_CTRL: next_prdata = {28'h0, prof, depth};
                ADDR_GAIN_RAW: next_prdata = {18'h0, gain};
                ADDR_GAIN_ABS: next_prdata = 32'(gain_db);
                ADDR_OFFS_RAW: next_prdata = 32'(offs);
                ADDR_OFFS_ABS: next_prdata = (depth == DEPTH_8B) ?
                    32'(offs >>> OFFS_SHIFT_8B) : (depth == DEPTH_10B) ?
                    32'(offs >>> OFFS_SHIFT_10B) : 32'(offs);
                ADDR_STATUS: next_prdata = {29'h0, range_err, busy, lval};
                default: next_prdata = 32'h0;
            endcase
        end
    end

    // Settings take their defaults on reset.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            depth <= DEPTH_RESET;
            prof <= PROF_RESET;
            gain <= GAIN_RESET;
            gain_db <= 8'sh00;
            offs <= OFFS_RESET;
            range_err <= 1'b0;
            PRDATA <= 32'h0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            depth <= next_depth;
            prof <= next_prof;
            gain <= next_gain;
            gain_db <= next_gain_db;
            offs <= next_offs;
            range_err <= next_range_err;
            PRDATA <= next_prdata;
            PREADY <= next_pready;
            PSLVERR <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------
    // Pixel datapath
    // ------------------------------------------------------------------
    logic [25:0] prod;
    logic signed [15:0] sum;
    logic [11:0] sat, pix_res;

    // Gain first, then offset in 12-bit units, so the coarse modes see
    // 16 or 4 units per count after the final shift.
    always_comb begin
        prod = 26'(PIX_DATA) * 26'(gain);
        sum = $signed({2'h0, prod[25:GAIN_SHIFT]}) + 16'(offs);
        if (sum < 16'sh0000) sat = 12'h000;
        else if (sum > 16'sh0fff) sat = 12'hfff;
        else sat = sum[11:0];
        case (depth)
            DEPTH_8B: pix_res = sat >> OFFS_SHIFT_8B;
            DEPTH_10B: pix_res = sat >> OFFS_SHIFT_10B;
            default: pix_res = sat;
        endcase
    end

    pix_skid #(
        .WIDTH(12)
    ) u_skid (
        .clk(CLK),
        .rst(SYS_RST),
        .in_data(pix_res),
        .in_valid(PIX_VALID),
        .in_ready(PIX_READY),
        .out_data(VID_DATA),
        .out_valid(VID_VALID),
        .out_ready(VID_READY)
    );

    // ------------------------------------------------------------------
    // Line-valid delay
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {LV_IDLE, LV_WAIT, LV_ACTIVE} lv_state_t;
    lv_state_t lv_state, next_lv_state;
    logic trig_s1, trig_s2, trig_d;
    logic [8:0] cnt, next_cnt, dly;
    logic next_lval;

    // The counts already allow for the two synchroniser stages.
    always_comb begin
        case (prof)
            PROF_DUAL_40: dly = 9'(LVD_D40_CYC);
            PROF_DUAL_80: dly = 9'(LVD_D80_CYC);
            default: dly = 9'(LVD_S40_CYC);
        endcase
        next_lv_state = lv_state;
        next_cnt = cnt;
        next_lval = 1'b0;
        case (lv_state)
            LV_IDLE: begin
                if (trig_s2 && !trig_d) begin
                    next_lv_state = LV_WAIT;
                    next_cnt = dly - 9'h001;
                end
            end
            LV_WAIT: begin
                if (!trig_s2) begin
                    next_lv_state = LV_IDLE;
                end else if (cnt == 9'h000) begin
                    next_lv_state = LV_ACTIVE;
                    next_lval = 1'b1;
                end else begin
                    next_cnt = cnt - 9'h001;
                end
            end
            LV_ACTIVE: begin
                next_lval = trig_s2;
                if (!trig_s2) next_lv_state = LV_IDLE;
            end
            default: next_lv_state = LV_IDLE;
        endcase
    end

    assign lval = LINE_VALID;
    assign busy = (lv_state == LV_WAIT);

    // Registers only; the trigger pin is synchronised first.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_d <= 1'b0;
            lv_state <= LV_IDLE;
            cnt <= 9'h000;
            LINE_VALID <= 1'b0;
        end else begin
            trig_s1 <= LINE_TRIG;
            trig_s2 <= trig_s1;
            trig_d <= trig_s2;
            lv_state <= next_lv_state;
            cnt <= next_cnt;
            LINE_VALID <= next_lval;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [8:0] wait_cyc;
    always_ff @(posedge CLK) begin
        if (SYS_RST || lv_state != LV_WAIT) wait_cyc <= 9'h000;
        else wait_cyc <= wait_cyc + 9'h001;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    gain_floor_a: assert property (gain >= GAIN_MIN)
        else $error("gain below minimum");
    gain_ceiling_a: assert property (gain <= gain_max(depth))
        else $error("gain above mode limit");
    gain_reset_a: assert property ($fell(SYS_RST) |-> gain == GAIN_RESET)
        else $error("gain not at default after reset");
    unity_pass_a: assert property ((gain == GAIN_RESET && offs == 13'sh0000 && depth == DEPTH_12B) |-> pix_res == PIX_DATA)
        else $error("unity gain altered pixel");
    abs_gain_a: assert property ((wr && PADDR == ADDR_GAIN_ABS && PWDATA[7:0] == 8'h00) |=> gain == GAIN_RESET)
        else $error("zero dB did not give unity");
    offs_reset_a: assert property ($fell(SYS_RST) |-> offs == OFFS_RESET)
        else $error("offset not zero after reset");
    offs_bound_a: assert property (offs <= offs_lim(depth) && offs >= -offs_lim(depth))
        else $error("offset outside mode range");
    abs_offs_a: assert property ((wr && PADDR == ADDR_OFFS_ABS && PWDATA[15:0] == 16'h0001 && depth == DEPTH_8B) |=> offs == 13'sh0010)
        else $error("one count did not give 16 units");
    lval_delay_a: assert property ($rose(LINE_VALID) |-> $past(wait_cyc) == dly - 9'h001)
        else $error("line valid delay wrong");
    sat_range_a: assert property (depth != DEPTH_8B || pix_res <= 12'h0ff)
        else $error("8-bit result not saturated");
    gain_clamp_a: assert property ((wr && PADDR == ADDR_GAIN_RAW && PWDATA[15:0] > 16'(gain_max(depth))) |=> gain == $past(gain_max(depth)))
        else $error("gain write not clamped");

    lval_rise_c: cover property ($rose(LINE_VALID));
    vid_stall_c: cover property (VID_VALID && !VID_READY ##1 !PIX_READY);
    range_err_c: cover property ($rose(range_err));
    sat_high_c: cover property (PIX_VALID && sat == 12'hfff);

endmodule // pix_gain_offset

// ### shared/pgo_pkg.sv
// ----------------------------------------------------------------------
// Register map, field layout and timing of the gain and offset stage
// ----------------------------------------------------------------------
package pgo_pkg;

    // Clock rate of the stage in MHz.
    localparam int CLK_MHZ = 25;

    // Register byte addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_GAIN_RAW = 8'h04;
    localparam logic [7:0] ADDR_GAIN_ABS = 8'h08;
    localparam logic [7:0] ADDR_OFFS_RAW = 8'h0c;
    localparam logic [7:0] ADDR_OFFS_ABS = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // Control and status field positions.
    localparam int CTRL_DEPTH_LSB = 0;
    localparam int CTRL_PROF_LSB = 2;
    localparam int STAT_LVAL_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_RANGE_BIT = 2;

    // Output bit-depth encodings.
    localparam logic [1:0] DEPTH_8B = 2'h0;
    localparam logic [1:0] DEPTH_10B = 2'h1;
    localparam logic [1:0] DEPTH_12B = 2'h2;
    localparam logic [1:0] DEPTH_RESET = DEPTH_12B;

    // Line-valid delay profiles.
    localparam logic [1:0] PROF_SINGLE_40 = 2'h0;
    localparam logic [1:0] PROF_DUAL_40 = 2'h1;
    localparam logic [1:0] PROF_DUAL_80 = 2'h2;
    localparam logic [1:0] PROF_RESET = PROF_SINGLE_40;

    // Gain settings; unity is 4096, so the product is shifted by 12.
    localparam logic [13:0] GAIN_RESET = 14'h1000;
    localparam logic [13:0] GAIN_MIN = 14'h0aab;
    localparam logic [13:0] GAIN_MAX_8B = 14'h3fff;
    localparam logic [13:0] GAIN_MAX_10B = 14'h2000;
    localparam logic [13:0] GAIN_MAX_12B = 14'h1800;
    localparam int GAIN_SHIFT = 12;

    // Absolute gain range in whole decibels.
    localparam logic signed [7:0] DB_MIN = -8'sh03;
    localparam logic signed [7:0] DB_MAX = 8'sh0c;

    // Offset settings and the units per output count of each mode.
    localparam logic signed [12:0] OFFS_RESET = 13'sh0000;
    localparam logic signed [12:0] OFFS_LIM_8B = 13'sh00ff;
    localparam logic signed [12:0] OFFS_LIM_10B = 13'sh03ff;
    localparam logic signed [12:0] OFFS_LIM_12B = 13'sh0fff;
    localparam int OFFS_SHIFT_8B = 4;
    localparam int OFFS_SHIFT_10B = 2;

    // Line-valid delay windows in ns and the resulting cycle counts.
    localparam int LVD_S40_MIN_NS = 9680;
    localparam int LVD_S40_MAX_NS = 9810;
    localparam int LVD_D40_MIN_NS = 9730;
    localparam int LVD_D40_MAX_NS = 9860;
    localparam int LVD_D80_MIN_NS = 12730;
    localparam int LVD_D80_MAX_NS = 12840;
    localparam int SYNC_LAT_CYC = 2;
    localparam int LVD_S40_CYC =
        (LVD_S40_MIN_NS * CLK_MHZ + 999) / 1000 - SYNC_LAT_CYC;
    localparam int LVD_D40_CYC =
        (LVD_D40_MIN_NS * CLK_MHZ + 999) / 1000 - SYNC_LAT_CYC;
    localparam int LVD_D80_CYC =
        (LVD_D80_MIN_NS * CLK_MHZ + 999) / 1000 - SYNC_LAT_CYC;
    localparam int LVD_S40_MAX_CYC = LVD_S40_MAX_NS * CLK_MHZ / 1000;
    localparam int LVD_D40_MAX_CYC = LVD_D40_MAX_NS * CLK_MHZ / 1000;
    localparam int LVD_D80_MAX_CYC = LVD_D80_MAX_NS * CLK_MHZ / 1000;

endpackage

// ### hdl/pix_skid.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Two-entry skid buffer with registered outputs on both sides
// ----------------------------------------------------------------------
module pix_skid #(
    parameter int WIDTH = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    logic [WIDTH-1:0] spare_data;
    logic spare_valid;
    logic [WIDTH-1:0] next_out_data;
    logic next_out_valid;
    logic [WIDTH-1:0] next_spare_data;
    logic next_spare_valid;

    // The spare entry catches the word accepted while the output stalls,
    // so ready can be a register and still lose nothing.
    always_comb begin
        next_out_data = out_data;
        next_out_valid = out_valid;
        next_spare_data = spare_data;
        next_spare_valid = spare_valid;
        if (out_ready || !out_valid) begin
            if (spare_valid) begin
                next_out_data = spare_data;
                next_out_valid = 1'b1;
                next_spare_valid = 1'b0;
            end else begin
                next_out_data = in_data;
                next_out_valid = in_valid && in_ready;
            end
        end else if (in_valid && in_ready) begin
            next_spare_data = in_data;
            next_spare_valid = 1'b1;
        end
    end

    // Registers only.
    always_ff @(posedge clk) begin
        if (rst) begin
            out_data <= '0;
            out_valid <= 1'b0;
            spare_data <= '0;
            spare_valid <= 1'b0;
            in_ready <= 1'b1;
        end else begin
            out_data <= next_out_data;
            out_valid <= next_out_valid;
            spare_data <= next_spare_data;
            spare_valid <= next_spare_valid;
            in_ready <= !next_spare_valid;
        end
    end

endmodule // pix_skid

// ### verif/vid_sink.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Frame grabber model that takes results and stalls now and then
// ----------------------------------------------------------------------
module vid_sink (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    output logic ready
);
    logic [1:0] cnt;
    logic [1:0] next_cnt;

    // A free count gives a regular gap, so the stage sees back pressure.
    always_comb begin
        next_cnt = rst ? 2'h0 : cnt + 2'h1;
    end

    always_ff @(posedge clk) begin
        cnt <= next_cnt;
    end

    // The bench may hold the grabber off entirely to fill the buffer.
    assign ready = !rst && !stall && (cnt != 2'h3);
endmodule // vid_sink

// ### verif/test_pixel_gain_offset_stage.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Self-checking bench of the gain and offset stage
// ----------------------------------------------------------------------
module test_pixel_gain_offset_stage;
    import pgo_pkg::*;
    logic CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic PIX_VALID = 0, LINE_TRIG = 0, stall = 0, err;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd, seed = 32'h30883f71;
    logic PREADY, PSLVERR, PIX_READY, VID_VALID, VID_READY, LINE_VALID;
    logic [11:0] PIX_DATA = 12'h000, VID_DATA;
    logic [11:0] q[$];
    int error_cnt = 0, checks = 0, gain = 4096, off = 0, sh = 0, dd = 2;
    int t0, k;
    int gmax[3] = '{16383, 8192, 6144};
    int olim[3] = '{255, 1023, 4095};
    int osh[3] = '{4, 2, 0};
    int lmin[3] = '{9680, 9730, 12730};
    int lmax[3] = '{9810, 9860, 12840};

    always #20 CLK = ~CLK;

    pix_gain_offset i_pix_gain_offset (.CLK(CLK), .SYS_RST(SYS_RST),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .PIX_DATA(PIX_DATA), .PIX_VALID(PIX_VALID),
        .PIX_READY(PIX_READY), .VID_DATA(VID_DATA), .VID_VALID(VID_VALID),
        .VID_READY(VID_READY), .LINE_TRIG(LINE_TRIG),
        .LINE_VALID(LINE_VALID));
    vid_sink i_vid_sink (.clk(CLK), .rst(SYS_RST), .stall(stall),
        .ready(VID_READY));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int clp(input int v, input int lo, input int hi);
        return v < lo ? lo : (v > hi ? hi : v);
    endfunction
    // Gain first, then offset at 12-bit scale, then cut to the depth.
    function automatic logic [11:0] expv(input logic [11:0] p);
        int r;
        r = clp(((int'(p) * gain) >>> 12) + off, 0, 4095);
        return 12'(r >>> sh);
    endfunction

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pix(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        if (error_cnt == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // One APB transfer; an idle edge after it keeps drives single-step.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic rdchk(input logic [7:0] a, input int exp);
        apb(1'b0, a, 32'h0);
        chk_reg(rd, 32'(exp));
    endtask
    // A depth change also pulls the settings back inside the new limits.
    task automatic mode(input int d, input int p);
        apb(1'b1, ADDR_CTRL, 32'(p * 4 + d));
        dd = d;
        sh = osh[d];
        gain = clp(gain, 2731, gmax[d]);
        off = clp(off, -olim[d], olim[d]);
    endtask
    task automatic setg(input int g);
        apb(1'b1, ADDR_GAIN_RAW, 32'(g));
        gain = clp(g, 2731, gmax[dd]);
    endtask
    task automatic seto(input int o);
        apb(1'b1, ADDR_OFFS_RAW, 32'(o) & 32'h0000ffff);
        off = clp(o, -olim[dd], olim[dd]);
    endtask
    // Expected values are noted at the edge that takes each pixel.
    task automatic burst(input int n);
        for (int i = 0; i < n; i++) begin
            PIX_DATA <= seed[11:0];
            seed = lfsr(seed);
            PIX_VALID <= 1'b1;
            do @(posedge CLK); while (PIX_READY !== 1'b1);
            q.push_back(expv(PIX_DATA));
        end
        PIX_VALID <= 1'b0;
        @(posedge CLK);
    endtask

    always @(posedge CLK) begin
        if (VID_VALID === 1'b1 && VID_READY === 1'b1)
            chk_pix(VID_DATA, q.size() > 0 ? q.pop_front() : ~VID_DATA);
    end

    initial begin
        repeat (30000) @(posedge CLK);
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (16) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        rdchk(ADDR_GAIN_RAW, 4096);
        rdchk(ADDR_OFFS_RAW, 0);
        burst(6);
        for (int d = 0; d < 3; d++) begin
            mode(d, 0);
            setg(16383);
            rdchk(ADDR_GAIN_RAW, gmax[d]);
            setg(100);
            rdchk(ADDR_GAIN_RAW, 2731);
            seto(-5000);
            rdchk(ADDR_OFFS_RAW, -olim[d]);
            burst(4);
            setg(gmax[d]);
            seto(olim[d]);
            burst(6);
            setg(5000);
            seto(-37);
            burst(8);
        end
        mode(0, 0);
        apb(1'b1, ADDR_GAIN_ABS, 32'd12);
        gain = 16306;
        rdchk(ADDR_GAIN_RAW, 16306);
        apb(1'b1, ADDR_GAIN_ABS, 32'h000000fd);
        gain = 2900;
        rdchk(ADDR_GAIN_RAW, 2900);
        burst(4);
        mode(1, 0);
        apb(1'b1, ADDR_OFFS_ABS, 32'd3);
        off = 12;
        rdchk(ADDR_OFFS_RAW, 12);
        burst(4);
        apb(1'b0, 8'h40, 32'h0);
        chk_reg({31'h0, err}, 32'h1);
        chk_reg(rd, 32'h0);
        // Hold the grabber off so both buffer entries fill up.
        stall <= 1'b1;
        burst(2);
        chk_reg({31'h0, PIX_READY}, 32'h0);
        stall <= 1'b0;
        for (int p = 0; p < 3; p++) begin
            mode(2, p);
            LINE_TRIG <= 1'b1;
            t0 = $time;
            k = 0;
            do begin
                @(posedge CLK);
                k++;
            end while (LINE_VALID !== 1'b1 && k < 400);
            t0 = $time - 40 - t0;
            chk_reg(32'(t0 >= lmin[p] && t0 <= lmax[p]), 32'h1);
            LINE_TRIG <= 1'b0;
            repeat (8) @(posedge CLK);
            chk_reg({31'h0, LINE_VALID}, 32'h0);
        end
        k = 0;
        while (q.size() > 0 && k < 50) begin
            @(posedge CLK);
            k++;
        end
        chk_reg(32'(q.size()), 32'h0);
        summarize();
    end
endmodule // test_pixel_gain_offset_stage
